// *** power_loss_ride_thru_restart_bench.sv ***
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
  err_total++; $display("Error %s expected %h seen %h", nm, exp, got); end end
`define WAITC(c, n) begin k = 0; do begin @(negedge sys_clk); k++; end \
  while (!(c) && k < (n)); end
module power_loss_ride_thru_restart_bench;
  logic        sys_clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic        power_on = 1, run_req = 0, slow = 0;
  logic        ctrl_power_ok = 1, ext_error = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd_val;
  logic        hready, hresp, irq, run_cmd, search_done;
  logic        output_enable, fault, error_out;
  logic [31:0] hrdata;
  logic [9:0]  bus_voltage;
  logic [7:0]  volt_scale;
  int          err_total = 0, checked = 0, k;
  logic [7:0]  ofs [8] = '{prtr_pkg::OFS_CTRL, prtr_pkg::OFS_RIDE,
    prtr_pkg::OFS_MINOFF, prtr_pkg::OFS_RAMP, prtr_pkg::OFS_LEVEL,
    prtr_pkg::OFS_STATUS, prtr_pkg::OFS_STATE, 8'h20};
  logic [31:0] rv [8] = '{32'h0, 32'(prtr_pkg::RIDE_RST),
    32'(prtr_pkg::MINOFF_RST), 32'(prtr_pkg::RAMP_RST),
    32'(prtr_pkg::LEVEL_RST), 32'h0, 32'(prtr_pkg::ST_NORMAL), 32'h0};

  prtr_sequencer #(.TICK_CYCLES(20), .RAMP_STEP_CYCLES(2)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .irq(irq), .bus_voltage(bus_voltage), .ctrl_power_ok(ctrl_power_ok),
    .run_cmd(run_cmd), .search_done(search_done), .ext_error(ext_error),
    .output_enable(output_enable), .volt_scale(volt_scale),
    .main_bus_undervoltage_fault(fault), .error_out(error_out));
  prtr_partner i_partner (.sys_clk(sys_clk), .power_on(power_on),
    .run_req(run_req), .slow(slow), .output_enable(output_enable),
    .bus_voltage(bus_voltage), .run_cmd(run_cmd),
    .search_done(search_done));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic xfer(input logic [7:0] a, input logic wr,
                      input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= prtr_pkg::HSIZE_WORD;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd_val = hrdata;
    `CHK("hresp", prtr_pkg::HRESP_OKAY, hresp)
  endtask

  // leave a trip: drop run with power back, then run again
  task automatic clear_trip();
    @(posedge sys_clk) run_req <= 1'b0;
    @(posedge sys_clk) power_on <= 1'b1;
    `WAITC(fault === 1'b0, 100)
    @(posedge sys_clk) run_req <= 1'b1;
    `WAITC(output_enable === 1'b1, 100)
    `CHK("run restarted", 1'b1, output_enable)
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge sys_clk);
    err_total++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      xfer(ofs[i], 1'b0, 32'h0);
      `CHK("reset value", rv[i], rd_val)
    end
    xfer(prtr_pkg::OFS_MINOFF, 1'b1, 32'h33);
    xfer(prtr_pkg::OFS_LEVEL, 1'b1, 32'h95);
    xfer(prtr_pkg::OFS_MINOFF, 1'b0, 32'h0);
    `CHK("min off kept", 32'h2, rd_val)
    xfer(prtr_pkg::OFS_LEVEL, 1'b0, 32'h0);
    `CHK("level kept", 32'hbe, rd_val)
    xfer(prtr_pkg::OFS_MASK, 1'b1, 32'h7);
    @(posedge sys_clk) run_req <= 1'b1;
    `WAITC(output_enable === 1'b1, 100)
    // mode 0: a 10 ms dip is ridden out, 15 ms is the limit
    @(posedge sys_clk) power_on <= 1'b0;
    `WAITC(1'b0, 200)
    `CHK("short dip oe", 1'b1, output_enable)
    @(posedge sys_clk) power_on <= 1'b1;
    `WAITC(1'b0, 20)
    @(posedge sys_clk) power_on <= 1'b0;
    `WAITC(1'b0, 300)
    `CHK("15 ms fault", 1'b0, fault)
    `WAITC(fault === 1'b1, 60)
    `CHK("mode0 fault", 1'b1, fault)
    `CHK("mode0 error", 1'b1, error_out)
    // irq is registered one cycle behind the status bit
    `WAITC(irq === 1'b1, 3)
    `CHK("irq raised", 1'b1, irq)
    xfer(prtr_pkg::OFS_STATUS, 1'b1, 32'h7);
    `WAITC(1'b0, 3)
    `CHK("irq cleared", 1'b0, irq)
    clear_trip();
    // mode 1: dip shorter than ride time, min off time longer
    xfer(prtr_pkg::OFS_CTRL, 1'b1, 32'h1);
    xfer(prtr_pkg::OFS_STATUS, 1'b1, 32'h7);
    @(posedge sys_clk) power_on <= 1'b0;
    @(posedge sys_clk) ext_error <= 1'b1;
    `WAITC(1'b0, 1000)
    `CHK("ride oe", 1'b0, output_enable)
    `CHK("ride error", 1'b0, error_out)
    @(posedge sys_clk) power_on <= 1'b1;
    `WAITC(1'b0, 2700)
    `CHK("min off oe", 1'b0, output_enable)
    `WAITC(output_enable === 1'b1, 400)
    `CHK("resume oe", 1'b1, output_enable)
    `CHK("search scale", 8'h00, volt_scale)
    `CHK("search error", 1'b0, error_out)
    `WAITC(volt_scale === 8'hff, 2000)
    `CHK("ramp scale", 8'hff, volt_scale)
    `CHK("ride fault", 1'b0, fault)
    xfer(prtr_pkg::OFS_STATUS, 1'b0, 32'h0);
    `CHK("events", 32'h6, rd_val)
    `CHK("error after", 1'b1, error_out)
    xfer(prtr_pkg::OFS_STATUS, 1'b1, 32'h7);
    @(posedge sys_clk) ext_error <= 1'b0;
    // mode 1: dip beyond the 100 ms ride time trips
    @(posedge sys_clk) power_on <= 1'b0;
    `WAITC(1'b0, 1900)
    `CHK("ride early", 1'b0, fault)
    `WAITC(fault === 1'b1, 400)
    `CHK("ride trip", 1'b1, fault)
    clear_trip();
    // run command dropped mid dip: no restart
    @(posedge sys_clk) power_on <= 1'b0;
    @(posedge sys_clk) run_req <= 1'b0;
    `WAITC(1'b0, 500)
    @(posedge sys_clk) power_on <= 1'b1;
    `WAITC(1'b0, 4500)
    `CHK("no restart", 1'b0, output_enable)
    @(posedge sys_clk) run_req <= 1'b1;
    `WAITC(output_enable === 1'b1, 100)
    // mode 2: long dip, control power held, slow search
    xfer(prtr_pkg::OFS_CTRL, 1'b1, 32'h2);
    @(posedge sys_clk) slow <= 1'b1;
    @(posedge sys_clk) power_on <= 1'b0;
    `WAITC(1'b0, 3000)
    `CHK("cpu fault", 1'b0, fault)
    `CHK("cpu oe", 1'b0, output_enable)
    @(posedge sys_clk) power_on <= 1'b1;
    `WAITC(volt_scale === 8'hff && output_enable === 1'b1, 6000)
    `CHK("cpu restart", 1'b1, output_enable)
    `CHK("cpu no fault", 1'b0, fault)
    // doubled level puts the healthy 280 V bus below 380 V
    xfer(prtr_pkg::OFS_CTRL, 1'b1, 32'h6);
    `WAITC(output_enable === 1'b0, 10)
    `CHK("class oe", 1'b0, output_enable)
    xfer(prtr_pkg::OFS_STATE, 1'b0, 32'h0);
    `CHK("class state", 32'(prtr_pkg::ST_LOSS), rd_val)
    end_sim();
  end
endmodule // power_loss_ride_thru_restart_bench

// *** prtr_cfg_if.sv ***
`timescale 1ns/100ps
interface prtr_cfg_if;
  logic [prtr_pkg::MODE_W-1:0] mode;
  logic                        high_class;
  logic [7:0]                  ride;
  logic [7:0]                  min_off;
  logic [7:0]                  ramp;
  logic [7:0]                  level;
  logic [prtr_pkg::EV_W-1:0]   events;
  logic [5:0]                  state_code;
  modport regs (output mode, high_class, ride, min_off, ramp, level,
                input events, state_code);
  modport core (input mode, high_class, ride, min_off, ramp, level,
                output events, state_code);
endinterface

// *** prtr_partner.sv ***
`timescale 1ns/100ps
module prtr_partner (
  input  wire logic       sys_clk,
  input  wire logic       power_on,
  input  wire logic       run_req,
  input  wire logic       slow,
  input  wire logic       output_enable,
  output logic [9:0]      bus_voltage,
  output logic            run_cmd,
  output logic            search_done
);
  logic [7:0] oe_cnt;

  // terminal run command is latched, so it survives the main power dip
  always_ff @(posedge sys_clk) begin
    run_cmd <= run_req;
  end

  // 280 V healthy bus, 100 V during a dip, both far from the 190 V level
  assign bus_voltage = power_on ? 10'h118 : 10'h064;

  // motor search finishes a few or many cycles after the stage is enabled
  always_ff @(posedge sys_clk) begin
    if (!output_enable)
      oe_cnt <= 8'h00;
    else if (oe_cnt != 8'hff)
      oe_cnt <= oe_cnt + 8'h01;
  end
  assign search_done = (oe_cnt == (slow ? 8'h28 : 8'h04));
endmodule // prtr_partner

// *** prtr_pkg.sv ***
package prtr_pkg;
  // timing base
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam int unsigned UNIT_MS_INT   = 100;
  localparam int unsigned RAMP_STEPS    = 256;
  localparam int unsigned RAMP_STEP_CYC =
    CLK_HZ / (MS_PER_S / UNIT_MS_INT) / RAMP_STEPS;
  localparam logic [15:0] UNIT_MS       = 16'h0064;
  localparam int unsigned UV_TRIP_TIME_MS = 15;
  localparam logic [15:0] UV_TRIP_MS    = 16'(UV_TRIP_TIME_MS);
  localparam logic [15:0] MS_MAX        = 16'hffff;
  localparam logic [7:0]  SCALE_MAX     = 8'hff;

  // loss handling modes
  localparam int unsigned MODE_W     = 2;
  localparam logic [1:0]  MODE_TRIP  = 2'h0;
  localparam logic [1:0]  MODE_TIMED = 2'h1;
  localparam logic [1:0]  MODE_CPU   = 2'h2;

  // setting resets and ranges, units of 0.1 s or volts
  localparam logic [7:0] RIDE_RST   = 8'h01;
  localparam logic [7:0] MINOFF_RST = 8'h02;
  localparam logic [7:0] MINOFF_MIN = 8'h01;
  localparam logic [7:0] MINOFF_MAX = 8'h32;
  localparam logic [7:0] RAMP_RST   = 8'h03;
  localparam logic [7:0] RAMP_MIN   = 8'h00;
  localparam logic [7:0] RAMP_MAX   = 8'h32;
  localparam logic [7:0] LEVEL_RST  = 8'hbe;
  localparam logic [7:0] LEVEL_MIN  = 8'h96;
  localparam logic [7:0] LEVEL_MAX  = 8'hd2;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RIDE   = 8'h04;
  localparam logic [7:0] OFS_MINOFF = 8'h08;
  localparam logic [7:0] OFS_RAMP   = 8'h0c;
  localparam logic [7:0] OFS_LEVEL  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK   = 8'h18;
  localparam logic [7:0] OFS_STATE  = 8'h1c;
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_CLASS_BIT = 2;

  // event bits in status and mask
  localparam int unsigned EV_TRIP    = 0;
  localparam int unsigned EV_LOSS    = 1;
  localparam int unsigned EV_RESTART = 2;
  localparam int unsigned EV_W       = 3;

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'b0;

  typedef enum logic [5:0] {
    ST_NORMAL = 6'h01,
    ST_LOSS   = 6'h02,
    ST_WAIT   = 6'h04,
    ST_SEARCH = 6'h08,
    ST_RAMP   = 6'h10,
    ST_TRIP   = 6'h20
  } prtr_state_t;

  function automatic logic [15:0] units_to_ms(input logic [7:0] u);
    return 16'(16'(u) * UNIT_MS);
  endfunction

  function automatic logic in_range(input logic [7:0] v,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction
endpackage

// *** prtr_regs.sv ***
`timescale 1ns/100ps
module prtr_regs (
  input  logic        sys_clk,
  input  logic        rst,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  output logic        irq,
  prtr_cfg_if.regs    cfg
);
  logic                      acc;
  logic                      wr_pend;
  logic [7:0]                wr_addr;
  logic [prtr_pkg::EV_W-1:0] status;
  logic [prtr_pkg::EV_W-1:0] mask;
  logic [prtr_pkg::EV_W-1:0] clr;
  logic [31:0]               rd_word;

  // only whole-word transfers are taken; others complete but do nothing
  assign acc = hsel && htrans[1] && hready && (hsize == prtr_pkg::HSIZE_WORD);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc && hwrite;
      if (acc) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  // out-of-range setting writes are dropped so the old value stays valid
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg.mode       <= prtr_pkg::MODE_TRIP;
      cfg.high_class <= 1'b0;
      cfg.ride       <= prtr_pkg::RIDE_RST;
      cfg.min_off    <= prtr_pkg::MINOFF_RST;
      cfg.ramp       <= prtr_pkg::RAMP_RST;
      cfg.level      <= prtr_pkg::LEVEL_RST;
      mask           <= '0;
    end else if (wr_pend) begin
      case (wr_addr)
        prtr_pkg::OFS_CTRL: begin
          if (hwdata[prtr_pkg::CTRL_MODE_LSB +: prtr_pkg::MODE_W]
              <= prtr_pkg::MODE_CPU) begin
            cfg.mode <= hwdata[prtr_pkg::CTRL_MODE_LSB +: prtr_pkg::MODE_W];
          end
          cfg.high_class <= hwdata[prtr_pkg::CTRL_CLASS_BIT];
        end
        prtr_pkg::OFS_RIDE: cfg.ride <= hwdata[7:0];
        prtr_pkg::OFS_MINOFF: begin
          if (prtr_pkg::in_range(hwdata[7:0], prtr_pkg::MINOFF_MIN,
                                 prtr_pkg::MINOFF_MAX)) begin
            cfg.min_off <= hwdata[7:0];
          end
        end
        prtr_pkg::OFS_RAMP: begin
          if (prtr_pkg::in_range(hwdata[7:0], prtr_pkg::RAMP_MIN,
                                 prtr_pkg::RAMP_MAX)) begin
            cfg.ramp <= hwdata[7:0];
          end
        end
        prtr_pkg::OFS_LEVEL: begin
          if (prtr_pkg::in_range(hwdata[7:0], prtr_pkg::LEVEL_MIN,
                                 prtr_pkg::LEVEL_MAX)) begin
            cfg.level <= hwdata[7:0];
          end
        end
        prtr_pkg::OFS_MASK: mask <= hwdata[prtr_pkg::EV_W-1:0];
        default: ;
      endcase
    end
  end

  assign clr = (wr_pend && (wr_addr == prtr_pkg::OFS_STATUS)) ?
               hwdata[prtr_pkg::EV_W-1:0] : '0;

  // set is or-ed in after the clear, so a same-cycle event survives
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~clr) | cfg.events;
      irq    <= |(status & mask);
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      prtr_pkg::OFS_CTRL: begin
        rd_word[prtr_pkg::CTRL_MODE_LSB +: prtr_pkg::MODE_W] = cfg.mode;
        rd_word[prtr_pkg::CTRL_CLASS_BIT] = cfg.high_class;
      end
      prtr_pkg::OFS_RIDE:   rd_word[7:0] = cfg.ride;
      prtr_pkg::OFS_MINOFF: rd_word[7:0] = cfg.min_off;
      prtr_pkg::OFS_RAMP:   rd_word[7:0] = cfg.ramp;
      prtr_pkg::OFS_LEVEL:  rd_word[7:0] = cfg.level;
      prtr_pkg::OFS_STATUS: rd_word[prtr_pkg::EV_W-1:0] = status;
      prtr_pkg::OFS_MASK:   rd_word[prtr_pkg::EV_W-1:0] = mask;
      prtr_pkg::OFS_STATE:  rd_word[5:0] = cfg.state_code;
      default: ;
    endcase
  end

  // zero wait states; read data latched at the address phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= prtr_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= prtr_pkg::HRESP_OKAY;
      if (acc && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end
endmodule // prtr_regs

// *** prtr_sequencer.sv ***
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// - mode 0: no ride-through, trip on loss
// - mode 1: restart if power returns in time
// - mode 1: loss beyond ride time trips
// - mode 2: restart while control power held
// - mode 2: loss never trips
// - ride time 0..25.5 s, used in mode 1
// - output off at least min off time
// - resume after min off if longer
// - ramp voltage back over recovery ramp time
// - undervoltage level 150..210 V, doubled high class
// - restart needs run command held throughout
// - error outputs held off during recovery
// - mode 0 running, dip over 15 ms trips
module prtr_sequencer #(
  parameter int unsigned TICK_CYCLES      = prtr_pkg::CYC_PER_MS,
  parameter int unsigned RAMP_STEP_CYCLES = prtr_pkg::RAMP_STEP_CYC
) (
  input  logic        sys_clk,
  input  logic        rst,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  output logic        irq,
  input  logic [9:0]  bus_voltage,
  input  logic        ctrl_power_ok,
  input  logic        run_cmd,
  input  logic        search_done,
  input  logic        ext_error,
  output logic        output_enable,
  output logic [7:0]  volt_scale,
  output logic        main_bus_undervoltage_fault,
  output logic        error_out
);
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("TICK_CYCLES must be 1..65535");
  end
  if (RAMP_STEP_CYCLES < 1 || RAMP_STEP_CYCLES > 20000) begin : g_bad_ramp
    $error("RAMP_STEP_CYCLES must be 1..20000");
  end

  prtr_cfg_if cfg_bus ();

  prtr_pkg::prtr_state_t state;
  prtr_pkg::prtr_state_t next_state;
  logic        uv;
  logic [8:0]  level_eff;
  logic [15:0] tick_cnt;
  logic        ms_tick;
  logic        tick_clr;
  logic [15:0] dip_ms;
  logic [15:0] loss_ms;
  logic [15:0] ride_ms;
  logic [15:0] min_off_ms;
  logic [19:0] ramp_cnt;
  logic [19:0] step_len;
  logic        running;
  logic        loss_start;
  logic        recovering;
  logic        next_recovering;

  prtr_regs u_regs (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .irq       (irq),
    .cfg       (cfg_bus.regs)
  );

  assign level_eff = cfg_bus.high_class ? {cfg_bus.level, 1'b0}
                                        : {1'b0, cfg_bus.level};
  assign ride_ms    = prtr_pkg::units_to_ms(cfg_bus.ride);
  assign min_off_ms = prtr_pkg::units_to_ms(cfg_bus.min_off);
  assign step_len   = 20'(cfg_bus.ramp) * 20'(RAMP_STEP_CYCLES);
  assign running    = run_cmd && output_enable;
  assign ms_tick    = (tick_cnt == 16'(TICK_CYCLES - 1));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uv <= 1'b0;
    end else begin
      uv <= bus_voltage < {1'b0, level_eff};
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      prtr_pkg::ST_NORMAL: begin
        if (running && uv) begin
          if (cfg_bus.mode == prtr_pkg::MODE_TRIP) begin
            if (dip_ms > prtr_pkg::UV_TRIP_MS) begin
              next_state = prtr_pkg::ST_TRIP;
            end
          end else begin
            next_state = prtr_pkg::ST_LOSS;
          end
        end
      end
      prtr_pkg::ST_LOSS: begin
        if (!run_cmd) begin
          next_state = prtr_pkg::ST_NORMAL;
        end else if (cfg_bus.mode == prtr_pkg::MODE_TRIP) begin
          next_state = prtr_pkg::ST_TRIP;
        end else if (cfg_bus.mode == prtr_pkg::MODE_TIMED &&
                     loss_ms > ride_ms) begin
          next_state = prtr_pkg::ST_TRIP;
        end else if (cfg_bus.mode == prtr_pkg::MODE_CPU &&
                     !ctrl_power_ok) begin
          next_state = prtr_pkg::ST_NORMAL;
        end else if (!uv) begin
          next_state = prtr_pkg::ST_WAIT;
        end
      end
      prtr_pkg::ST_WAIT: begin
        if (!run_cmd) begin
          next_state = prtr_pkg::ST_NORMAL;
        end else if (uv) begin
          next_state = prtr_pkg::ST_LOSS;
        end else if (loss_ms >= min_off_ms) begin
          next_state = prtr_pkg::ST_SEARCH;
        end
      end
      prtr_pkg::ST_SEARCH: begin
        if (!run_cmd) begin
          next_state = prtr_pkg::ST_NORMAL;
        end else if (uv) begin
          next_state = prtr_pkg::ST_LOSS;
        end else if (search_done) begin
          next_state = prtr_pkg::ST_RAMP;
        end
      end
      prtr_pkg::ST_RAMP: begin
        if (!run_cmd) begin
          next_state = prtr_pkg::ST_NORMAL;
        end else if (uv) begin
          next_state = prtr_pkg::ST_LOSS;
        end else if (volt_scale == prtr_pkg::SCALE_MAX) begin
          next_state = prtr_pkg::ST_NORMAL;
        end
      end
      prtr_pkg::ST_TRIP: begin
        if (!run_cmd && !uv) begin
          next_state = prtr_pkg::ST_NORMAL;
        end
      end
      default: next_state = prtr_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= prtr_pkg::ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  assign loss_start = (next_state == prtr_pkg::ST_LOSS) &&
                      (state != prtr_pkg::ST_LOSS) &&
                      (state != prtr_pkg::ST_WAIT);
  // the ms prescaler restarts with each timed interval so no interval
  // comes out up to a millisecond short
  assign tick_clr = (state == prtr_pkg::ST_NORMAL && !uv) || loss_start;

  always_ff @(posedge sys_clk) begin
    if (rst || tick_clr || ms_tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || state != prtr_pkg::ST_NORMAL || !uv) begin
      dip_ms <= 16'h0000;
    end else if (ms_tick && dip_ms != prtr_pkg::MS_MAX) begin
      dip_ms <= dip_ms + 16'h0001;
    end
  end

  // one timer covers the loss and the wait, so min off counts from loss
  always_ff @(posedge sys_clk) begin
    if (rst || loss_start) begin
      loss_ms <= 16'h0000;
    end else if ((state == prtr_pkg::ST_LOSS || state == prtr_pkg::ST_WAIT)
                 && ms_tick && loss_ms != prtr_pkg::MS_MAX) begin
      loss_ms <= loss_ms + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ramp_cnt   <= 20'h00000;
      volt_scale <= prtr_pkg::SCALE_MAX;
    end else if (next_state != prtr_pkg::ST_RAMP) begin
      ramp_cnt   <= 20'h00000;
      volt_scale <= (next_state == prtr_pkg::ST_NORMAL) ?
                    prtr_pkg::SCALE_MAX : 8'h00;
    end else if (step_len == 20'h00000) begin
      volt_scale <= prtr_pkg::SCALE_MAX;
    end else if (ramp_cnt >= step_len - 20'h00001) begin
      ramp_cnt   <= 20'h00000;
      volt_scale <= volt_scale + 8'h01;
    end else begin
      ramp_cnt <= ramp_cnt + 20'h00001;
    end
  end

  assign next_recovering = (next_state == prtr_pkg::ST_LOSS) ||
                           (next_state == prtr_pkg::ST_WAIT) ||
                           (next_state == prtr_pkg::ST_SEARCH) ||
                           (next_state == prtr_pkg::ST_RAMP);
  assign recovering = (state == prtr_pkg::ST_LOSS) ||
                      (state == prtr_pkg::ST_WAIT) ||
                      (state == prtr_pkg::ST_SEARCH) ||
                      (state == prtr_pkg::ST_RAMP);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      output_enable               <= 1'b0;
      main_bus_undervoltage_fault <= 1'b0;
      error_out                   <= 1'b0;
    end else begin
      output_enable <= (next_state == prtr_pkg::ST_NORMAL && run_cmd) ||
                       next_state == prtr_pkg::ST_SEARCH ||
                       next_state == prtr_pkg::ST_RAMP;
      main_bus_undervoltage_fault <= next_state == prtr_pkg::ST_TRIP;
      error_out <= (ext_error || next_state == prtr_pkg::ST_TRIP) &&
                   !next_recovering;
    end
  end

  always_comb begin
    cfg_bus.events = '0;
    cfg_bus.events[prtr_pkg::EV_TRIP] = (next_state == prtr_pkg::ST_TRIP) &&
                                        (state != prtr_pkg::ST_TRIP);
    cfg_bus.events[prtr_pkg::EV_LOSS] = loss_start;
    cfg_bus.events[prtr_pkg::EV_RESTART] =
      (state == prtr_pkg::ST_RAMP) && (next_state == prtr_pkg::ST_NORMAL);
  end
  assign cfg_bus.state_code = state;

  property p_mode0_trip;
    @(posedge sys_clk) disable iff (rst)
    state == prtr_pkg::ST_NORMAL && cfg_bus.mode == prtr_pkg::MODE_TRIP &&
    running && uv && dip_ms > prtr_pkg::UV_TRIP_MS
    |=> state == prtr_pkg::ST_TRIP && main_bus_undervoltage_fault;
  endproperty
  a_mode0_trip: assert property (p_mode0_trip)
    else $error("mode 0 dip beyond limit did not trip");

  property p_mode0_no_ride;
    @(posedge sys_clk) disable iff (rst)
    cfg_bus.mode == prtr_pkg::MODE_TRIP && state == prtr_pkg::ST_NORMAL
    |=> state != prtr_pkg::ST_LOSS;
  endproperty
  a_mode0_no_ride: assert property (p_mode0_no_ride)
    else $error("mode 0 entered ride-through");

  property p_timed_restart;
    @(posedge sys_clk) disable iff (rst)
    state == prtr_pkg::ST_LOSS && cfg_bus.mode == prtr_pkg::MODE_TIMED &&
    run_cmd && !uv && loss_ms <= ride_ms |=> state == prtr_pkg::ST_WAIT;
  endproperty
  a_timed_restart: assert property (p_timed_restart)
    else $error("return of power within ride time not followed");

  property p_timed_trip;
    @(posedge sys_clk) disable iff (rst)
    state == prtr_pkg::ST_LOSS && cfg_bus.mode == prtr_pkg::MODE_TIMED &&
    run_cmd && loss_ms > ride_ms
    |=> state == prtr_pkg::ST_TRIP ##1 main_bus_undervoltage_fault;
  endproperty
  a_timed_trip: assert property (p_timed_trip)
    else $error("loss beyond ride time did not trip");

  property p_cpu_restart;
    @(posedge sys_clk) disable iff (rst)
    state == prtr_pkg::ST_LOSS && cfg_bus.mode == prtr_pkg::MODE_CPU &&
    run_cmd && ctrl_power_ok && !uv |=> state == prtr_pkg::ST_WAIT;
  endproperty
  a_cpu_restart: assert property (p_cpu_restart)
    else $error("mode 2 did not proceed to restart");

  property p_cpu_never_trip;
    @(posedge sys_clk) disable iff (rst)
    cfg_bus.mode == prtr_pkg::MODE_CPU && state != prtr_pkg::ST_TRIP
    |=> !main_bus_undervoltage_fault;
  endproperty
  a_cpu_never_trip: assert property (p_cpu_never_trip)
    else $error("mode 2 raised the undervoltage fault");

  property p_min_off;
    @(posedge sys_clk) disable iff (rst)
    $rose(state == prtr_pkg::ST_SEARCH) && $past(state) == prtr_pkg::ST_WAIT
    |-> $past(loss_ms) >= min_off_ms && output_enable;
  endproperty
  a_min_off: assert property (p_min_off)
    else $error("output resumed before min off time");

  property p_off_in_loss;
    @(posedge sys_clk) disable iff (rst)
    state == prtr_pkg::ST_LOSS || state == prtr_pkg::ST_WAIT
    |-> !output_enable;
  endproperty
  a_off_in_loss: assert property (p_off_in_loss)
    else $error("output on while inhibited");

  property p_ramp_done;
    @(posedge sys_clk) disable iff (rst)
    state == prtr_pkg::ST_SEARCH && search_done && run_cmd && !uv &&
    cfg_bus.ramp != 8'h00
    |=> state == prtr_pkg::ST_RAMP && volt_scale <= 8'h01;
  endproperty
  a_ramp_done: assert property (p_ramp_done)
    else $error("ramp did not start from zero after search");

  property p_level;
    @(posedge sys_clk) disable iff (rst)
    !$past(rst) |-> uv == $past(bus_voltage < {1'b0, level_eff});
  endproperty
  a_level: assert property (p_level)
    else $error("undervoltage compare wrong");

  property p_run_held;
    @(posedge sys_clk) disable iff (rst)
    (state == prtr_pkg::ST_LOSS || state == prtr_pkg::ST_WAIT) && !run_cmd
    |=> state == prtr_pkg::ST_NORMAL ##1 !output_enable;
  endproperty
  a_run_held: assert property (p_run_held)
    else $error("restart without held run command");

  property p_quiet_recovery;
    @(posedge sys_clk) disable iff (rst)
    recovering |-> !error_out && !main_bus_undervoltage_fault;
  endproperty
  a_quiet_recovery: assert property (p_quiet_recovery)
    else $error("error output during recovery");

  property p_timer_start;
    @(posedge sys_clk) disable iff (rst)
    loss_start |=> loss_ms == 16'h0000 && tick_cnt == 16'h0000;
  endproperty
  a_timer_start: assert property (p_timer_start)
    else $error("loss timer not restarted at detection");
endmodule // prtr_sequencer
